// [verilog/cdrlm_defs.vh]
// Purpose: constants for the recovery-loop lock-mode controller and deserializer
// Assumes: 100 MHz i_clk, classic Wishbone register access
// Notes:   offsets, control and divider field positions, their reset values and the timing count live here
`ifndef CDRLM_DEFS_VH
`define CDRLM_DEFS_VH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define CDRLM_ADR_CTRL     8'h00
`define CDRLM_ADR_STATUS   8'h04
`define CDRLM_ADR_DIV      8'h08
`define CDRLM_ADR_DATA     8'h0C

// ----------------------------------------
// Control fields
// ----------------------------------------
`define CDRLM_CTRL_MANUAL  0
`define CDRLM_CTRL_PCIE    1
`define CDRLM_CTRL_FDATA   2
`define CDRLM_CTRL_FREF    3
`define CDRLM_CTRL_RST     8'h00

// ----------------------------------------
// Divider fields and reset value
// ----------------------------------------
`define CDRLM_DIV_N_LSB    0
`define CDRLM_DIV_M_LSB    4
`define CDRLM_DIV_LR_LSB   12
`define CDRLM_DIV_LD_LSB   16
`define CDRLM_DIV_RST      20'h11011

// ----------------------------------------
// Timing
// ----------------------------------------
`define CDRLM_LOCK_US      4
`define CDRLM_CLK_MHZ      100
`define CDRLM_LOCK_CYC     (`CDRLM_LOCK_US * `CDRLM_CLK_MHZ)
`define CDRLM_WORD_W       10

`endif

// [verilog/cdrlm_sync.v]
// Purpose: two-flop level synchroniser, one per bit
// Assumes: inputs are slow levels
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
module cdrlm_sync #(
  parameter W = 3
) (
  input  wire         i_clk,     // System clock
  input  wire         i_sys_rst, // Sync reset, high
  input  wire [W-1:0] i_d,       // Asynchronous levels
  output wire [W-1:0] o_q        // Synchronised levels
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      always @(posedge i_clk) begin
        if (i_sys_rst) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= i_d[g];
          s2_q[g] <= s1_q[g];
        end
      end
    end
  endgenerate
  assign o_q = s2_q;
endmodule // cdrlm_sync

// [verilog/cdrlm_deser.v]
// Purpose: serial-to-parallel converter with clock slip
// Assumes: one serial bit per i_clk cycle when i_bit_vld is high
// Notes:   a slip holds the word boundary back by one bit
`include "cdrlm_defs.vh"
`timescale 1ns/1ps
module cdrlm_deser (
  input  wire                     i_clk,      // System clock
  input  wire                     i_sys_rst,  // Sync reset, high
  input  wire                     i_bit,      // Recovered serial bit
  input  wire                     i_bit_vld,  // Bit valid strobe
  input  wire                     i_slip,     // Clock slip pulse
  output reg  [`CDRLM_WORD_W-1:0] o_word,     // Parallel word
  output reg                      o_word_vld  // Word valid pulse
);
  reg [`CDRLM_WORD_W-1:0] sh_q;
  reg [3:0]               cnt_q;
  reg                     slip_q;

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      sh_q       <= 10'h000;
      cnt_q      <= 4'h0;
      slip_q     <= 1'b0;
      o_word     <= 10'h000;
      o_word_vld <= 1'b0;
    end else begin
      o_word_vld <= 1'b0;
      if (i_slip)
        slip_q <= 1'b1;
      if (i_bit_vld) begin
        if (slip_q && !i_slip) begin
          slip_q <= 1'b0; // Drop one bit to shift boundary
        end else begin
          sh_q <= {i_bit, sh_q[`CDRLM_WORD_W-1:1]}; // First bit ends LSB
          if (cnt_q == 4'h9) begin
            cnt_q      <= 4'h0;
            o_word     <= {i_bit, sh_q[`CDRLM_WORD_W-1:1]};
            o_word_vld <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
      end
    end
  end
endmodule // cdrlm_deser

// [verilog/cdrlm_top.v]
// Purpose: lock-mode controller for the recovery loop, with deserializer and Wishbone registers
// Assumes: frequency/phase comparator results arrive as synchronous levels
// Notes:   analog loop itself lives outside; this block steers o_mode_data
//
// Our own choices: the address map and the Wishbone register port.
`include "cdrlm_defs.vh"
`timescale 1ns/1ps
module cdrlm_top (
  input  wire                     i_clk,         // System clock 100 MHz
  input  wire                     i_sys_rst,     // Sync reset, high (PMA reset)
  input  wire                     i_wb_cyc,      // Wishbone cycle
  input  wire                     i_wb_stb,      // Wishbone strobe
  input  wire                     i_wb_we,       // Wishbone write
  input  wire [7:0]               i_wb_adr,      // Wishbone byte address
  input  wire [3:0]               i_wb_sel,      // Wishbone byte enables
  input  wire [31:0]              i_wb_dat,      // Wishbone write data
  output reg  [31:0]              o_wb_dat,      // Wishbone read data
  output reg                      o_wb_ack,      // Wishbone acknowledge
  output reg                      o_wb_err,      // Wishbone error
  input  wire                     i_freq_ok,     // Frequency within ppm threshold
  input  wire                     i_phase_ok,    // Phase within 0.08 UI
  input  wire                     i_sig_det,     // Signal above idle threshold
  input  wire                     i_ref_lock,    // Reference lock from comparator
  input  wire                     i_force_data,  // Pin force-data-lock
  input  wire                     i_force_ref,   // Pin force-reference-lock
  input  wire                     i_bit,         // Recovered serial bit
  input  wire                     i_bit_vld,     // Serial bit strobe
  input  wire                     i_slip,        // Slip from word aligner
  output reg                      o_mode_data,   // Loop in data tracking
  output reg                      o_data_lock,   // Data-lock flag
  output reg                      o_ref_lock,    // Masked reference lock
  output reg  [`CDRLM_WORD_W-1:0] o_word,        // Deserialized word
  output reg                      o_word_vld     // Word valid pulse
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [1:0] ST_REF  = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_LOCK = 2'h2;

  // Count kept in nine bits; cut on purpose from the integer product
  localparam integer LOCK_CYC_I = `CDRLM_LOCK_CYC;
  localparam [8:0]   LOCK_CYC   = LOCK_CYC_I[8:0];

  // ----------------------------------------
  // Legal divider checks
  // ----------------------------------------
  function pow2_ok;
    input [3:0] v;
    begin
      pow2_ok = (v == 4'h1) || (v == 4'h2) || (v == 4'h4) || (v == 4'h8);
    end
  endfunction

  function mult_ok;
    input [7:0] v;
    begin
      case (v)
        8'h01, 8'h04, 8'h05, 8'h08, 8'h0A, 8'h0C, 8'h10, 8'h14, 8'h19: mult_ok = 1'b1;
        default: mult_ok = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  wire [2:0] sync_w;
  cdrlm_sync #(.W(3)) u_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_d       ({i_sig_det, i_force_ref, i_force_data}),
    .o_q       (sync_w)
  );
  wire sig_det_s = sync_w[2];
  wire fref_s    = sync_w[1];
  wire fdata_s   = sync_w[0];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg  [7:0]  ctrl_q;
  reg  [19:0] div_q;
  reg  [1:0]  st_q;
  reg  [1:0]  st_d;
  reg  [8:0]  cnt_q;
  reg  [7:0]  div_err_q;
  reg  [9:0]  last_word_q;

  wire manual   = ctrl_q[`CDRLM_CTRL_MANUAL];
  wire pcie     = ctrl_q[`CDRLM_CTRL_PCIE];
  wire fdata    = ctrl_q[`CDRLM_CTRL_FDATA] | fdata_s;
  wire fref     = ctrl_q[`CDRLM_CTRL_FREF]  | fref_s;
  wire sig_ok   = !pcie || sig_det_s;

  // Force-reference wins when both forced, safer for the loop
  wire go_data   = manual ? (fdata && !fref)
                          : (i_freq_ok && i_phase_ok && sig_ok);
  wire drop_data = manual ? (fref || !fdata)
                          : (!i_freq_ok || !sig_ok);

  // ----------------------------------------
  // Mode state machine
  // ----------------------------------------
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_REF:  if (go_data) st_d = ST_WAIT;
      ST_WAIT: if (drop_data) st_d = ST_REF;
               else if (cnt_q == LOCK_CYC - 9'h001) st_d = ST_LOCK;
      ST_LOCK: if (drop_data) st_d = ST_REF;
      default: st_d = ST_REF;
    endcase
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_q        <= ST_REF;
      cnt_q       <= 9'h000;
      o_mode_data <= 1'b0;
      o_data_lock <= 1'b0;
      o_ref_lock  <= 1'b0;
    end else begin
      st_q        <= st_d;
      cnt_q       <= (st_q == ST_WAIT && st_d == ST_WAIT) ? cnt_q + 9'h001 : 9'h000;
      o_mode_data <= (st_d != ST_REF);
      o_data_lock <= (st_d == ST_LOCK);
      o_ref_lock  <= (st_d == ST_REF) && i_ref_lock;
    end
  end

  // ----------------------------------------
  // Deserializer
  // ----------------------------------------
  wire [`CDRLM_WORD_W-1:0] word_w;
  wire                     word_vld_w;
  cdrlm_deser u_deser (
    .i_clk      (i_clk),
    .i_sys_rst  (i_sys_rst),
    .i_bit      (i_bit),
    .i_bit_vld  (i_bit_vld && o_mode_data),
    .i_slip     (i_slip),
    .o_word     (word_w),
    .o_word_vld (word_vld_w)
  );

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_word      <= 10'h000;
      o_word_vld  <= 1'b0;
      last_word_q <= 10'h000;
    end else begin
      o_word_vld <= word_vld_w;
      if (word_vld_w) begin
        o_word      <= word_w;
        last_word_q <= word_w;
      end
    end
  end

  // ----------------------------------------
  // Wishbone slave, ack (or err for an unmapped address) one cycle after request
  // ----------------------------------------
  wire req     = i_wb_cyc && i_wb_stb && !o_wb_ack && !o_wb_err;
  wire hit_ctl = (i_wb_adr == `CDRLM_ADR_CTRL);
  wire hit_st  = (i_wb_adr == `CDRLM_ADR_STATUS);
  wire hit_div = (i_wb_adr == `CDRLM_ADR_DIV);
  wire hit_dat = (i_wb_adr == `CDRLM_ADR_DATA);
  wire mapped  = hit_ctl || hit_st || hit_div || hit_dat;

  wire [19:0] div_new = {i_wb_sel[2] ? i_wb_dat[19:16] : div_q[19:16],
                         i_wb_sel[1] ? i_wb_dat[15:8]  : div_q[15:8],
                         i_wb_sel[0] ? i_wb_dat[7:0]   : div_q[7:0]};
  wire div_legal = pow2_ok(div_new[`CDRLM_DIV_N_LSB +: 4])
                && mult_ok(div_new[`CDRLM_DIV_M_LSB +: 8])
                && pow2_ok(div_new[`CDRLM_DIV_LR_LSB +: 4])
                && pow2_ok(div_new[`CDRLM_DIV_LD_LSB +: 4]);

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_q    <= `CDRLM_CTRL_RST;
      div_q     <= `CDRLM_DIV_RST;
      div_err_q <= 8'h00;
      o_wb_ack  <= 1'b0;
      o_wb_err  <= 1'b0;
      o_wb_dat  <= 32'h0000_0000;
    end else begin
      o_wb_ack <= req && mapped;
      o_wb_err <= req && !mapped;
      if (req && i_wb_we) begin
        if (hit_ctl && i_wb_sel[0])
          ctrl_q <= {4'h0, i_wb_dat[3:0]};
        if (hit_div) begin
          if (div_legal)
            div_q <= div_new;
          else if (div_err_q != 8'hFF)
            div_err_q <= div_err_q + 8'h01; // Illegal values refused and counted
        end
      end
      if (req && !i_wb_we) begin
        case (1'b1)
          hit_ctl: o_wb_dat <= {24'h000000, ctrl_q};
          hit_st:  o_wb_dat <= {16'h0000, div_err_q, 1'b0, sig_det_s, st_q,
                                1'b0, o_ref_lock, o_data_lock, o_mode_data};
          hit_div: o_wb_dat <= {12'h000, div_q};
          hit_dat: o_wb_dat <= {22'h000000, last_word_q};
          default: o_wb_dat <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // cdrlm_top

// [bench/cdrlm_props.sv]
// Purpose: checker for lock-mode controller and register port
// Assumes: 100 MHz i_clk, synchronous high reset
// Notes:   control bits are shadowed from bus writes
`timescale 1ns/1ps
module cdrlm_props (
  input wire        i_clk,
  input wire        i_sys_rst,
  input wire        i_wb_cyc,
  input wire        i_wb_stb,
  input wire        i_wb_we,
  input wire [7:0]  i_wb_adr,
  input wire [3:0]  i_wb_sel,
  input wire [31:0] i_wb_dat,
  input wire        o_wb_ack,
  input wire        o_wb_err,
  input wire        i_freq_ok,
  input wire        i_phase_ok,
  input wire        o_mode_data,
  input wire        o_data_lock,
  input wire        o_ref_lock,
  input wire        o_word_vld
);
  reg  [3:0] ctrl_q;
  reg  [9:0] hold_q;
  wire       take   = i_wb_cyc & i_wb_stb & ~o_wb_ack & ~o_wb_err;
  wire       mapped = (i_wb_adr[7:4] == 4'h0) && (i_wb_adr[1:0] == 2'h0);
  always @(posedge i_clk) begin
    if (i_sys_rst)
      ctrl_q <= 4'h0;
    else if (take & i_wb_we & mapped & (i_wb_adr[3:2] == 2'h0) & i_wb_sel[0])
      ctrl_q <= i_wb_dat[3:0];
  end
  // Cycles spent in data tracking, saturating
  always @(posedge i_clk) begin
    if (i_sys_rst | ~o_mode_data)
      hold_q <= 10'h000;
    else if (hold_q != 10'h3FF)
      hold_q <= hold_q + 10'h001;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
  ack_latency_a: assert property (take && mapped |=> o_wb_ack && !o_wb_err) else $error("no ack");
  err_unmapped_a: assert property (take && !mapped |=> o_wb_err && !o_wb_ack) else $error("no err");
  reset_ref_a: assert property (disable iff (1'b0) i_sys_rst |=> !o_mode_data && !o_data_lock)
    else $error("data tracking after reset");
  auto_enter_a: assert property ($rose(o_mode_data) && !ctrl_q[0] |-> $past(i_freq_ok) && $past(i_phase_ok))
    else $error("entry without frequency and phase");
  auto_drop_a: assert property (!ctrl_q[0] && o_mode_data && !i_freq_ok |=> !o_mode_data && !o_data_lock)
    else $error("no drop on frequency error");
  lock_delay_a: assert property ($rose(o_data_lock) |-> hold_q == 10'h190) else $error("lock delay wrong");
  lock_mode_a: assert property (o_data_lock |-> o_mode_data) else $error("lock outside data tracking");
  ref_mask_a: assert property (o_mode_data && $past(o_mode_data) |-> !o_ref_lock) else $error("ref lock unmasked");
  manual_ref_a: assert property (ctrl_q[0] && ctrl_q[3] |-> ##[1:3] !o_mode_data)
    else $error("force reference ignored");
  word_pulse_a: assert property (o_word_vld |=> !o_word_vld) else $error("word valid too long");
endmodule // cdrlm_props

// [bench/cdrlm_far_end.sv]
// Purpose: remote serial transmitter and local PCS reset logic
// Assumes: one bit per clock while sending
// Notes:   released line shows the inverse of the last bit
`timescale 1ns/1ps
module cdrlm_far_end (
  input  wire  i_clk,       // System clock
  input  wire  i_data_lock, // Data-lock flag
  output logic o_bit = 1'b0, // Serial bit
  output logic o_bit_vld = 1'b0, // Bit strobe
  output wire  o_pcs_rst    // Receiver PCS reset
);
  assign o_pcs_rst = ~i_data_lock;
  task send_bit(input logic b);
    @(posedge i_clk);
    o_bit     <= b;
    o_bit_vld <= 1'b1;
  endtask
  task send_word(input logic [9:0] w);
    for (int k = 0; k < 10; k++)
      send_bit(w[k]);
    @(posedge i_clk);
    o_bit     <= ~o_bit;
    o_bit_vld <= 1'b0;
  endtask
endmodule // cdrlm_far_end

// [bench/cdrlm_tb_top.sv]
// Purpose: self-checking bench for lock-mode controller
// Assumes: Wishbone ack after one cycle, 400-cycle lock delay
// Notes:   register cases in a table, mode cases by hand
`timescale 1ns/1ps
module cdrlm_tb_top;
  typedef struct {logic we; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} cdrlm_row_t;
  logic i_clk = 0, i_sys_rst = 1, cyc = 0, stb = 0, we = 0, slip = 0, err;
  logic freq_ok = 0, phase_ok = 0, sig_det = 1, ref_lock = 1, f_data = 0, f_ref = 0;
  logic [7:0] adr = 0;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 0, rd;
  wire [31:0] o_wb_dat;
  wire [9:0] o_word;
  wire o_wb_ack, o_wb_err, o_mode_data, o_data_lock, o_ref_lock, o_word_vld, bit_w, bit_vld;
  int error_cnt = 0, n_compared = 0, cyc_cnt = 0, n;
  cdrlm_row_t rows [11] = '{
    '{0, 8'h00, 0, 32'h0, 0}, '{0, 8'h08, 0, 32'h0001_1011, 0},
    '{1, 8'h08, 32'h0008_2148, 0, 0}, '{0, 8'h08, 0, 32'h0008_2148, 0},
    '{1, 8'h08, 32'h0008_2143, 0, 0}, '{1, 8'h08, 32'h0008_2038, 0, 0},
    '{0, 8'h08, 0, 32'h0008_2148, 0}, '{1, 8'h08, 32'h0001_1191, 0, 0},
    '{0, 8'h08, 0, 32'h0001_1191, 0}, '{0, 8'h04, 0, 32'h0000_0244, 0},
    '{0, 8'h14, 0, 32'h0, 1}};
  cdrlm_top u_dut (.i_clk, .i_sys_rst, .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat, .o_wb_ack, .o_wb_err, .i_freq_ok(freq_ok),
    .i_phase_ok(phase_ok), .i_sig_det(sig_det), .i_ref_lock(ref_lock), .i_force_data(f_data),
    .i_force_ref(f_ref), .i_bit(bit_w), .i_bit_vld(bit_vld), .i_slip(slip), .o_mode_data,
    .o_data_lock, .o_ref_lock, .o_word, .o_word_vld);
  cdrlm_far_end u_far (.i_clk, .i_data_lock(o_data_lock),
    .o_bit(bit_w), .o_bit_vld(bit_vld), .o_pcs_rst()); // Loop only ever used for recovery
  initial forever #5 i_clk = ~i_clk;
  task stop_test;
    if (error_cnt == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 5000) begin
      error_cnt++;
      stop_test;
    end
  end
  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, x, s);
    end
  endtask
  // Single classic cycle; answer taken at the edge that sees it
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (!(o_wb_ack | o_wb_err) && n < 50);
    rd  = o_wb_dat;
    err = o_wb_err;
    chk("answer", n < 50, 1);
    {cyc, stb} <= 2'b00;
  endtask
  task wait_mode(input logic v);
    n = 0;
    while (o_mode_data !== v && n < 50) begin
      @(negedge i_clk);
      n++;
    end
    chk("mode", o_mode_data, v);
  endtask
  task get_word(input logic [9:0] x);
    n = 0;
    while (o_word_vld !== 1'b1 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    chk("word", o_word, x);
  endtask
  initial begin
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    foreach (rows[i]) begin
      wb(rows[i].we, rows[i].a, rows[i].d);
      chk("err", err, rows[i].e);
      if (!rows[i].we && !rows[i].e) chk("rdata", rd, rows[i].x);
    end
    @(posedge i_clk) freq_ok <= 1'b1;
    repeat (5) @(negedge i_clk);
    chk("mode", o_mode_data, 0);
    @(posedge i_clk) phase_ok <= 1'b1;
    wait_mode(1);
    n = 0;
    while (o_data_lock !== 1'b1 && n < 1000) begin
      @(negedge i_clk);
      n++;
    end
    chk("lock_time", n, 400);
    chk("ref_lock", o_ref_lock, 0);
    u_far.send_word(10'h2B5);
    get_word(10'h2B5);
    @(posedge i_clk) slip <= 1'b1;
    @(posedge i_clk) slip <= 1'b0;
    u_far.send_bit(1'b1);
    u_far.send_word(10'h0C3);
    get_word(10'h0C3);
    @(posedge i_clk) freq_ok <= 1'b0;
    repeat (2) @(negedge i_clk);
    chk("drop", {o_mode_data, o_data_lock}, 0);
    @(posedge i_clk) sig_det <= 1'b0;
    wb(1, 8'h00, 32'h2);
    @(posedge i_clk) freq_ok <= 1'b1;
    repeat (10) @(negedge i_clk);
    chk("pcie_mode", o_mode_data, 0);
    @(posedge i_clk) sig_det <= 1'b1;
    wait_mode(1);
    @(posedge i_clk) sig_det <= 1'b0;
    wait_mode(0);
    @(posedge i_clk) {sig_det, freq_ok} <= 2'b10;
    wb(1, 8'h00, 32'h5);
    wait_mode(1);
    wb(1, 8'h00, 32'hD);
    wait_mode(0);
    wb(1, 8'h00, 32'h1);
    @(posedge i_clk) {f_data, freq_ok} <= 2'b11;
    wait_mode(1);
    @(posedge i_clk) {f_ref, freq_ok} <= 2'b10;
    wait_mode(0);
    @(posedge i_clk) {f_data, f_ref, freq_ok} <= 3'b001;
    wb(1, 8'h00, 32'h0);
    wait_mode(1);
    @(posedge i_clk) i_sys_rst <= 1'b1;
    repeat (2) @(negedge i_clk);
    chk("reset_mode", {o_mode_data, o_data_lock}, 0);
    @(posedge i_clk) i_sys_rst <= 1'b0;
    wb(0, 8'h08, 0);
    chk("div_reset", rd, 32'h0001_1011);
    sel <= 4'hE;
    wb(1, 8'h08, 32'h0008_20FF);
    sel <= 4'hF;
    wb(0, 8'h08, 0);
    chk("div_sel", rd, 32'h0008_2011);
    stop_test;
  end
endmodule // cdrlm_tb_top
bind cdrlm_top cdrlm_props u_props (.i_clk, .i_sys_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
  .i_wb_dat, .o_wb_ack, .o_wb_err, .i_freq_ok, .i_phase_ok, .o_mode_data, .o_data_lock, .o_ref_lock, .o_word_vld);
